// ---- rtl/asr_pkg.sv ----
// package: constants and carrier types for the shared-bus serial read-out
package asr_pkg;

    localparam int RESULT_W = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] BITS_PER_WORD = 5'h10;
    localparam int CLK_MHZ = 125;
    localparam int TIMEOUT_MS = 28;
    // longest time rounds down
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int PULLUP_BIT = 3;
    localparam int MUX_LSB = 4;
    localparam logic PULLUP_RESET = 1'b0;
    localparam logic [2:0] MUX_RESET = 3'h0;

    // input selections: four single-ended, three against the common point
    typedef enum logic [2:0] {
        ASR_MUX_ZERO_GND = 3'b000,
        ASR_MUX_ONE_GND = 3'b001,
        ASR_MUX_TWO_GND = 3'b010,
        ASR_MUX_THREE_GND = 3'b011,
        ASR_MUX_ZERO_THREE = 3'b100,
        ASR_MUX_ONE_THREE = 3'b101,
        ASR_MUX_TWO_THREE = 3'b110
    } asr_mux_t;

    typedef struct packed {
        logic [RESULT_W-1:0] data;
        asr_mux_t sel;
    } asr_result_t;

    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_SHIFT = 2'b01,
        ASR_DONE = 2'b10
    } asr_state_t;

endpackage : asr_pkg

// ---- rtl/asr_readout.sv ----
// serial read-out logic for a converter on a shared four-wire bus
`timescale 1ns/1ps

module asr_readout #(
    parameter int TIMEOUT_CYCLES = asr_pkg::TIMEOUT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [7:0] config_i,
    input wire logic conv_valid_i,
    input wire logic [asr_pkg::RESULT_W-1:0] conv_data_i,
    output logic conv_ready_o,
    output logic [2:0] mux_sel_o,
    output logic serial_out_ready_pin_o,
    output logic serial_out_ready_pin_oe_n_o,
    output logic pullup_en_o,
    output logic timeout_o
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic sclk_d;
    logic cs_d;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cs_sync <= 2'h3;
            sclk_sync <= 2'h0;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end
        else
        begin
            cs_sync <= {cs_sync[0], cs_n_i};
            sclk_sync <= {sclk_sync[0], sclk_i};
            sclk_d <= sclk_sync[1];
            cs_d <= cs_sync[1];
        end
    end

    logic cs_lo;
    logic cs_fall;
    logic sclk_rise;
    assign cs_lo = !cs_sync[1];
    assign cs_fall = cs_d && !cs_sync[1];
    assign sclk_rise = sclk_sync[1] && !sclk_d;

    // ----------------------------------------
    // configuration
    // ----------------------------------------
    function automatic asr_pkg::asr_mux_t decode_mux(input logic [2:0] code);
        decode_mux = (code == 3'h7) ? asr_pkg::ASR_MUX_ZERO_GND : asr_pkg::asr_mux_t'(code);
    endfunction : decode_mux

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pullup_en_o <= asr_pkg::PULLUP_RESET;
            mux_sel_o <= asr_pkg::MUX_RESET;
        end
        else
        begin
            pullup_en_o <= config_i[asr_pkg::PULLUP_BIT];
            mux_sel_o <= decode_mux(config_i[asr_pkg::MUX_LSB +: 3]);
        end
    end

    // ----------------------------------------
    // two-entry result buffer
    // ----------------------------------------
    asr_pkg::asr_result_t buf_mem [2];
    logic [1:0] buf_cnt;
    logic buf_rd;
    logic buf_wr;
    logic buf_rp;
    logic buf_wp;
    logic take;

    assign buf_wr = conv_valid_i && conv_ready_o;
    assign buf_rd = take && (buf_cnt != 2'h0);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            buf_cnt <= 2'h0;
            buf_rp <= 1'b0;
            buf_wp <= 1'b0;
            conv_ready_o <= 1'b1;
        end
        else
        begin
            if (buf_wr)
            begin
                buf_wp <= !buf_wp;
            end
            if (buf_rd)
            begin
                buf_rp <= !buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd};
            conv_ready_o <= (buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd}) != 2'h2;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (buf_wr)
        begin
            buf_mem[buf_wp] <= '{data: conv_data_i, sel: asr_pkg::asr_mux_t'(mux_sel_o)};
        end
    end

    // ----------------------------------------
    // transfer engine
    // ----------------------------------------
    asr_pkg::asr_state_t state;
    logic [asr_pkg::RESULT_W-1:0] last_result;
    logic [asr_pkg::RESULT_W-1:0] shifter;
    logic [asr_pkg::CNT_W-1:0] bit_cnt;
    logic [31:0] idle_cnt;
    logic tmo;
    logic fresh;

    assign fresh = buf_cnt != 2'h0;
    assign take = cs_lo && sclk_rise && (state == asr_pkg::ASR_IDLE);
    assign tmo = cs_lo && (state == asr_pkg::ASR_SHIFT) && (idle_cnt >= 32'(TIMEOUT_CYCLES));

    // clock-low watchdog, cleared by any clock activity
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            idle_cnt <= 32'h0;
        end
        else if (sclk_sync[1] || !cs_lo || state != asr_pkg::ASR_SHIFT)
        begin
            idle_cnt <= 32'h0;
        end
        else
        begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= asr_pkg::ASR_IDLE;
            shifter <= '0;
            last_result <= '0;
            bit_cnt <= '0;
            timeout_o <= 1'b0;
        end
        else
        begin
            timeout_o <= tmo;
            unique case (state)
                asr_pkg::ASR_IDLE:
                begin
                    if (take)
                    begin
                        // snapshot once; later conversions cannot tear it
                        if (fresh)
                        begin
                            shifter <= buf_mem[buf_rp].data;
                            last_result <= buf_mem[buf_rp].data;
                        end
                        else
                        begin
                            shifter <= last_result;
                        end
                        bit_cnt <= asr_pkg::CNT_W'(1);
                        state <= asr_pkg::ASR_SHIFT;
                    end
                end
                asr_pkg::ASR_SHIFT:
                begin
                    if (!cs_lo || tmo)
                    begin
                        bit_cnt <= '0;
                        state <= asr_pkg::ASR_IDLE;
                    end
                    else if (sclk_rise)
                    begin
                        shifter <= {shifter[asr_pkg::RESULT_W-2:0], 1'b0};
                        bit_cnt <= bit_cnt + asr_pkg::CNT_W'(1);
                        if (bit_cnt == asr_pkg::BITS_PER_WORD)
                        begin
                            state <= asr_pkg::ASR_DONE;
                        end
                    end
                end
                asr_pkg::ASR_DONE:
                begin
                    if (!cs_lo)
                    begin
                        bit_cnt <= '0;
                        state <= asr_pkg::ASR_IDLE;
                    end
                end
                default:
                begin
                    state <= asr_pkg::ASR_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // shared pin drive
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            serial_out_ready_pin_o <= 1'b1;
            serial_out_ready_pin_oe_n_o <= 1'b1;
        end
        else if (!cs_lo)
        begin
            // weak pull-up is modelled as value high with driver off
            serial_out_ready_pin_oe_n_o <= 1'b1;
            serial_out_ready_pin_o <= 1'b1;
        end
        else
        begin
            serial_out_ready_pin_oe_n_o <= 1'b0;
            if (state == asr_pkg::ASR_SHIFT)
            begin
                serial_out_ready_pin_o <= (bit_cnt == '0) ? 1'b0 : shifter[asr_pkg::RESULT_W-1];
            end
            else if (take)
            begin
                serial_out_ready_pin_o <= fresh ? buf_mem[buf_rp].data[asr_pkg::RESULT_W-1]
                                                : last_result[asr_pkg::RESULT_W-1];
            end
            else if (state == asr_pkg::ASR_IDLE)
            begin
                serial_out_ready_pin_o <= !fresh;
            end
            else
            begin
                serial_out_ready_pin_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_release;
        @(posedge clk_i) disable iff (!rst_n_i) cs_sync[1] |=> serial_out_ready_pin_oe_n_o;
    endproperty
    a_release: assert property (p_release) else $error("pin driven while deselected");

    property p_no_ready_high;
        @(posedge clk_i) disable iff (!rst_n_i) cs_sync[1] |=> serial_out_ready_pin_o;
    endproperty
    a_no_ready_high: assert property (p_no_ready_high) else $error("ready shown while deselected");

    property p_drive_on_fall;
        @(posedge clk_i) disable iff (!rst_n_i) cs_fall |=> !serial_out_ready_pin_oe_n_o;
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("pin not driven after select");

    property p_ready_low;
        @(posedge clk_i) disable iff (!rst_n_i)
            cs_fall && fresh && state == asr_pkg::ASR_IDLE && !sclk_rise |=> !serial_out_ready_pin_o;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("fresh data not flagged low");

    property p_stale_high;
        @(posedge clk_i) disable iff (!rst_n_i)
            cs_fall && !fresh && state == asr_pkg::ASR_IDLE && !sclk_rise |=> serial_out_ready_pin_o;
    endproperty
    a_stale_high: assert property (p_stale_high) else $error("stale data not flagged high");

    property p_latch;
        @(posedge clk_i) disable iff (!rst_n_i)
            take && fresh |=> shifter == $past(buf_mem[buf_rp].data) && state == asr_pkg::ASR_SHIFT;
    endproperty
    a_latch: assert property (p_latch) else $error("result not latched on first edge");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
            state == asr_pkg::ASR_SHIFT && !sclk_rise && cs_lo && !tmo |=> $stable(shifter);
    endproperty
    a_hold: assert property (p_hold) else $error("shifter changed without clock");

    property p_timeout;
        @(posedge clk_i) disable iff (!rst_n_i) tmo |=> state == asr_pkg::ASR_IDLE && bit_cnt == '0 ##0 timeout_o;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not reset transfer");

    property p_pullup;
        @(posedge clk_i) disable iff (!rst_n_i) 1'b1 |=> pullup_en_o == $past(config_i[asr_pkg::PULLUP_BIT]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up enable not following bit");

    c_fresh_read: cover property (@(posedge clk_i) disable iff (!rst_n_i) take && fresh);
    c_stale_read: cover property (@(posedge clk_i) disable iff (!rst_n_i) take && !fresh);
    c_timeout: cover property (@(posedge clk_i) disable iff (!rst_n_i) tmo);
    c_full: cover property (@(posedge clk_i) disable iff (!rst_n_i) !conv_ready_o);

endmodule : asr_readout

// ---- bench/asr_spi_master.sv ----
// partner model: four-wire bus master reading one word per select
`timescale 1ns/1ps
module asr_spi_master (
    input wire logic clk_i,
    input wire logic pin_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic rdy_o,
    output logic [15:0] word_o,
    output logic done_o
);
    // serial clock stands low outside frames
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        rdy_o = 1'b1;
        word_o = 16'h0000;
        done_o = 1'b0;
    end

    task pulse();
        sclk_o = 1'b1;
        repeat (4) @(negedge clk_i);
        sclk_o = 1'b0;
        repeat (3) @(negedge clk_i);
        // sampled late in the low phase: the device sees the clock through a synchroniser
        word_o = {word_o[14:0], pin_i};
        @(negedge clk_i);
    endtask : pulse

    task run(input int cut, input int to);
        int i;
        @(negedge clk_i);
        cs_n_o = 1'b0; // own select, polled level
        repeat (8) @(negedge clk_i);
        rdy_o = pin_i;
        for (i = 0; i < cut; i++) pulse();
        // gap beyond the limit only when asked, otherwise gaps stay short
        if (cut > 0) repeat (to + 20) @(negedge clk_i);
        for (i = 0; i < 16; i++) pulse();
        done_o = 1'b1;
        @(negedge clk_i);
        done_o = 1'b0;
        cs_n_o = 1'b1;
        repeat (8) @(negedge clk_i);
    endtask : run
endmodule : asr_spi_master

// ---- bench/tb.sv ----
// testbench: shared-bus read-out against the master model
`timescale 1ns/1ps
module tb;
    localparam int TO = 200;
    typedef struct packed {logic rdy; logic [15:0] word;} asr_exp_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cfg = 8'h00;
    logic conv_valid = 1'b0;
    logic [15:0] conv_data = 16'h0000;
    logic cs_n, sclk, pin_o, oe_n, pullup_en, conv_ready, timeout, m_rdy, m_done;
    logic [2:0] mux_sel;
    logic [15:0] m_word;
    wire pin_w = oe_n ? (pullup_en ? 1'b1 : 1'bz) : pin_o;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_to = 0;
    int seed = 32'h7F1ACE90;
    logic [15:0] fifo_m[$];
    logic [15:0] last_m;
    asr_exp_t exp_q[$];
    asr_exp_t e_w;

    always #4 clk = ~clk;

    asr_readout #(.TIMEOUT_CYCLES(TO)) i_dut (.clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
        .config_i(cfg), .conv_valid_i(conv_valid), .conv_data_i(conv_data), .conv_ready_o(conv_ready),
        .mux_sel_o(mux_sel), .serial_out_ready_pin_o(pin_o), .serial_out_ready_pin_oe_n_o(oe_n),
        .pullup_en_o(pullup_en), .timeout_o(timeout));
    asr_spi_master i_master (.clk_i(clk), .pin_i(pin_w), .cs_n_o(cs_n), .sclk_o(sclk), .rdy_o(m_rdy),
        .word_o(m_word), .done_o(m_done));

    // ------------------------------------------------
    // compare and closing
    // ------------------------------------------------
    task chk1(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask : chk1

    task chk16(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk16

    task test_done();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // ------------------------------------------------
    // drivers
    // ------------------------------------------------
    task push(input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        conv_valid = 1'b1;
        conv_data = d;
        while (conv_ready !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 50) chk1("conv_ready_wait", 1'b1, conv_ready);
        @(posedge clk);
        @(negedge clk);
        conv_valid = 1'b0;
        fifo_m.push_back(d);
    endtask : push

    // fresh word pops the oldest; otherwise the last read repeats
    task note();
        asr_exp_t e;
        if (fifo_m.size() > 0)
        begin
            e.rdy = 1'b0;
            e.word = fifo_m.pop_front();
            last_m = e.word;
        end
        else
        begin
            e.rdy = 1'b1;
            e.word = last_m;
        end
        exp_q.push_back(e);
    endtask : note

    task idle_chk();
        chk1("pin_idle", cfg[3] ? 1'b1 : 1'bz, pin_w);
        chk1("pullup_en", cfg[3], pullup_en);
    endtask : idle_chk

    task xfer(input int cut);
        note();
        i_master.run(cut, TO);
        idle_chk();
    endtask : xfer

    // ------------------------------------------------
    // result watcher
    // ------------------------------------------------
    always @(posedge clk)
    begin
        if (timeout === 1'b1) n_to++;
        if (m_done === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk1("spare_word", 1'b0, 1'b1);
            else
            begin
                e_w = exp_q.pop_front();
                chk1("ready_level", e_w.rdy, m_rdy);
                chk16("word", e_w.word, m_word);
            end
        end
    end

    initial
    begin : main
        int i;
        int k;
        int t0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        for (i = 0; i < 8; i++)
        begin
            cfg[6:4] = i[2:0];
            repeat (3) @(negedge clk);
            chk16("mux_sel", {13'h0000, (i == 7) ? 3'h0 : i[2:0]}, {13'h0000, mux_sel});
        end
        idle_chk();
        k = $random(seed);
        push(k[15:0]);
        repeat (4) @(negedge clk);
        xfer(0);
        xfer(0);
        cfg[3] = 1'b1;
        repeat (3) @(negedge clk);
        idle_chk();
        k = $random(seed);
        push(k[15:0]);
        push(k[31:16]);
        repeat (2) @(negedge clk);
        chk1("conv_ready_full", 1'b0, conv_ready);
        xfer(0);
        xfer(0);
        xfer(0);
        // a word arriving mid-transfer waits for the next select
        note();
        fork
            i_master.run(0, TO);
            begin
                repeat (40) @(negedge clk);
                k = $random(seed);
                push(k[15:0]);
            end
        join
        xfer(0);
        k = $random(seed);
        push(k[15:0]);
        repeat (4) @(negedge clk);
        t0 = n_to;
        xfer(5);
        chk16("timeouts", 16'(t0 + 1), 16'(n_to));
        for (i = 0; i < 6; i++)
        begin
            k = $random(seed);
            if (k[0]) push(k[31:16]);
            if (k[1] && fifo_m.size() < 2) push(k[23:8]);
            cfg[3] = k[2];
            repeat (4 + k[6:3]) @(negedge clk);
            xfer(0);
        end
        test_done();
    end

    // run needs some 20 us; the limit leaves wide margin
    initial
    begin
        #300000;
        n_mismatch++;
        test_done();
    end
endmodule : tb
